//--- inc/sts_map.svh
`ifndef STS_MAP_SVH
`define STS_MAP_SVH
// Notes on behaviour
// (R1) On normal: two lamps, both relays energized.
// (R2) Fixed 0.8 s dropout, normal lamps stay lit.
// (R3) Normal back during dropout cancels it.
// (R4) Dropout over: lamps out, start delay runs.
// (R5) Normal back during start delay: no start.
// (R6) Start delay over: drop start relay, start.
// (R7) Start lamp lit exactly while run requested.
// (R8) Emergency lamp lit while generator voltage good, except in start delay.
// (R9) Emergency good: transfer delay with timing lamp.
// (R10) Transfer delay over: energize transfer relay.
// (R11) On emergency: emergency, transfer, start lamps.
// (R12) Retransfer only in automatic position.
// (R13) Normal back: retransfer delay with timing lamp.
// (R14) Retransfer delay over: energize retransfer relay.
// (R15) After retransfer: stop delay with timing lamp.
// (R16) Stop delay over: re-energize start relay, stop.
// (R17) Test held low for whole test period.
// (R18) Test request: drop start relay, send start.
// (R19) No-load test: both available, no transfer.
// (R20) Load test acts as normal failure.
// (R21) No-load test end: stop at once.
// (R22) Load test end: retransfer, then stop delay.
// (R23) Relays never both on; one common tick.

// Clock and time base.
`define STS_CLK_PERIOD_NS 5
`define STS_TICK_MS 100
`define STS_TICK_CYCLES ((`STS_TICK_MS * 1000000) / `STS_CLK_PERIOD_NS)
`define STS_MS_TICKS(ms) ((ms) / `STS_TICK_MS)
`define STS_S_TICKS(s) (((s) * 1000) / `STS_TICK_MS)
`define STS_MIN_TICKS(m) (((m) * 60000) / `STS_TICK_MS)

// Delays as printed, then the dropout tick count.
`define STS_DROPOUT_MS 800
`define STS_START_FIX_S 3
`define STS_START_MIN_MS 500
`define STS_START_MAX_S 15
`define STS_XFER_FIX_S 3
`define STS_XFER_MIN_S 2
`define STS_XFER_MAX_S 120
`define STS_RETX_FIX_MIN 5
`define STS_RETX_MIN_S 6
`define STS_RETX_MAX_MIN 30
`define STS_STOP_FIX_MIN 5
`define STS_STOP_MIN_S 2
`define STS_STOP_MAX_MIN 10
`define STS_DROPOUT_TICKS `STS_MS_TICKS(`STS_DROPOUT_MS)
`define STS_TIMER_W 15

// Positions of the single-bit pins in the sampled vector.
`define STS_PIN_W 7
`define STS_PIN_NORMAL 0
`define STS_PIN_EMERG 1
`define STS_PIN_TEST_N 2
`define STS_PIN_EXER_N 3
`define STS_PIN_AUTO 4
`define STS_PIN_LOAD 5
`define STS_PIN_ADJ 6

// Idle levels of the sampled pins: normal good, no test requested.
`define STS_RST_PINS 7'h0D

// Reset values of the relay drives.
`define STS_RST_GEN_START 1'b1
`define STS_RST_RETX_RELAY 1'b0
`define STS_RST_XFER_RELAY 1'b0
`endif

//--- inc/sts_pkg.sv
package sts_pkg;
  // Sequencer states, Gray coded along the outage and return path.
  typedef enum logic [2:0] {
    STS_NORMAL = 3'h0,
    STS_DROPOUT = 3'h1,
    STS_START_DLY = 3'h3,
    STS_WAIT_EMERG = 3'h2,
    STS_XFER_DLY = 3'h6,
    STS_ON_EMERG = 3'h7,
    STS_RETX_DLY = 3'h5,
    STS_STOP_DLY = 3'h4
  } sts_state_type;

  // Holds an adjustable preset inside its allowed window.
  function automatic logic [14:0] sts_clamp(input logic [14:0] val, input logic [14:0] lo,
                                            input logic [14:0] hi);
    sts_clamp = (val < lo) ? lo : ((val > hi) ? hi : val);
  endfunction
endpackage

//--- inc/sts_timer_if.sv
`timescale 1ns/1ps
// Carries the time-base tick and the delay timer handshake.
interface sts_timer_if #(parameter int W = 15);
  logic tick;
  logic start;
  logic [W-1:0] preset;
  logic expired;
  modport base (output tick);
  modport timer (input tick, input start, input preset, output expired);
  modport ctrl (output start, output preset, input expired);
endinterface

//--- rtl/sts_time_base.sv
`timescale 1ns/1ps
// Divides the system clock down to the common delay tick.
module sts_time_base #(
  parameter int TICK_CYCLES = 20000000
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Tick out.
  sts_timer_if.base tif
);
  localparam int CW = $clog2(TICK_CYCLES);

  // Divider count and the registered tick.
  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } sts_base_state_type;

  sts_base_state_type s;
  sts_base_state_type next_s;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("Tick divider needs at least two cycles.");
  end

  // Counts to the end of a period and pulses the tick once.
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count == CW'(TICK_CYCLES - 1)) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + CW'(1);
    end
  end

  // Registers the divider state.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tif.tick = s.tick;
endmodule

//--- rtl/sts_delay_timer.sv
`timescale 1ns/1ps
// One-shot delay timer counting common ticks from a loaded preset.
module sts_delay_timer #(
  parameter int W = 15
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Tick in, handshake with the sequencer.
  sts_timer_if.timer tif
);
  // Remaining ticks, run flag and sticky expiry.
  typedef struct packed {
    logic [W-1:0] count;
    logic running;
    logic expired;
  } sts_timer_state_type;

  sts_timer_state_type s;
  sts_timer_state_type next_s;

  if (W < 15) begin : g_chk
    $error("Timer too narrow for the longest delay.");
  end

  // A start reloads the preset; a zero preset never expires.
  always_comb begin
    next_s = s;
    if (tif.start) begin
      next_s.count = tif.preset;
      next_s.running = (tif.preset != '0);
      next_s.expired = 1'b0;
    end else if (tif.tick && s.running) begin
      if (s.count <= W'(1)) begin
        next_s.count = '0;
        next_s.running = 1'b0;
        next_s.expired = 1'b1;
      end else begin
        next_s.count = s.count - W'(1);
      end
    end
  end

  // Registers the timer state.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tif.expired = s.expired;
endmodule

//--- rtl/sts_sequencer.sv
`timescale 1ns/1ps
`include "sts_map.svh"
// Transfer panel sequencer: timing, relay drives and status lamps.
module sts_sequencer
  import sts_pkg::*;
#(
  parameter int TICK_CYCLES = `STS_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Source sensors, high while the source is within its settings.
  input wire logic normal_avail_i,
  input wire logic emerg_avail_i,
  // Test requests, low while requested.
  input wire logic remote_test_input_n_i,
  input wire logic test_request_terminal_n_i,
  // Panel switches.
  input wire logic auto_manual_selector_i,
  input wire logic load_select_switch_i,
  input wire logic adjustable_pkg_i,
  // Adjustable presets in 100 ms ticks.
  input wire logic [14:0] start_delay_cfg_i,
  input wire logic [14:0] xfer_delay_cfg_i,
  input wire logic [14:0] retx_delay_cfg_i,
  input wire logic [14:0] stop_delay_cfg_i,
  // Relay drives, high while energized.
  output logic gen_start_relay_o,
  output logic transfer_control_relay_o,
  output logic retransfer_control_relay_o,
  // Three-wire start module command, high to run.
  output logic start_3wire_o,
  // Status lamps.
  output logic lamp_normal_avail_o,
  output logic lamp_emerg_avail_o,
  output logic lamp_xfer_timing_o,
  output logic lamp_retx_timing_o,
  output logic lamp_xfer_active_o,
  output logic lamp_retx_active_o,
  output logic lamp_start_o,
  output logic lamp_stop_timing_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State and local constants.
  ////////////////////////////////////////////////////////////////////////////

  localparam int SW = `STS_PIN_W + 4 * `STS_TIMER_W;

  // All flip-flops of the sequencer in one record.
  typedef struct packed {
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    sts_state_type state;
    logic restart;
    logic gen_start;
    logic xfer_relay;
    logic retx_relay;
    logic start_3wire;
    logic [7:0] lamps;
  } sts_seq_state_type;

  sts_seq_state_type s;
  sts_seq_state_type next_s;

  // Timer handshake shared with the divider and the delay timer.
  sts_timer_if #(.W(`STS_TIMER_W)) tif ();

  // Sampled pins, read only from the second stage.
  logic [`STS_PIN_W-1:0] pin;
  logic [14:0] cfg_start;
  logic [14:0] cfg_xfer;
  logic [14:0] cfg_retx;
  logic [14:0] cfg_stop;

  // Derived conditions.
  logic test_on;
  logic load_test;
  logic normal_eff;
  logic emerg_ok;
  logic timed_out;
  logic run_req;

  // Preset chosen for the current state.
  logic [14:0] preset;

  ////////////////////////////////////////////////////////////////////////////
  // Time base and delay timer.
  ////////////////////////////////////////////////////////////////////////////

  // (R23) Shared tick source.
  sts_time_base #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_base (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .tif(tif)
  );

  // Single timer reused by every delay, reloaded on each state change.
  sts_delay_timer #(
    .W(`STS_TIMER_W)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .tif(tif)
  );

  assign tif.start = s.restart;
  assign tif.preset = preset;

  ////////////////////////////////////////////////////////////////////////////
  // Input decoding.
  ////////////////////////////////////////////////////////////////////////////

  // Splits the second synchroniser stage into pins and presets.
  always_comb begin
    pin = s.sync2[`STS_PIN_W-1:0];
    cfg_start = s.sync2[`STS_PIN_W +: 15];
    cfg_xfer = s.sync2[`STS_PIN_W + 15 +: 15];
    cfg_retx = s.sync2[`STS_PIN_W + 30 +: 15];
    cfg_stop = s.sync2[`STS_PIN_W + 45 +: 15];
  end

  // Forms the working view of both sources and of a test.
  always_comb begin
    // (R17) Either grounded request holds a test.
    test_on = !pin[`STS_PIN_TEST_N] || !pin[`STS_PIN_EXER_N];
    load_test = test_on && pin[`STS_PIN_LOAD];
    // (R20) Load test masks normal.
    normal_eff = pin[`STS_PIN_NORMAL] && !load_test;
    emerg_ok = pin[`STS_PIN_EMERG];
    // An expiry left over from the previous state is ignored.
    timed_out = tif.expired && !s.restart;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preset selection.
  ////////////////////////////////////////////////////////////////////////////

  // Fixed or clamped adjustable delay for the state just entered.
  always_comb begin
    case (s.state)
      // (R2) Fixed dropout delay.
      STS_DROPOUT: begin
        preset = 15'(`STS_DROPOUT_TICKS);
      end
      // (R4) Start delay preset.
      STS_START_DLY: begin
        preset = pin[`STS_PIN_ADJ]
          ? sts_clamp(cfg_start, 15'(`STS_MS_TICKS(`STS_START_MIN_MS)),
                      15'(`STS_S_TICKS(`STS_START_MAX_S)))
          : 15'(`STS_S_TICKS(`STS_START_FIX_S));
      end
      // (R9) Transfer delay preset.
      STS_XFER_DLY: begin
        preset = pin[`STS_PIN_ADJ]
          ? sts_clamp(cfg_xfer, 15'(`STS_S_TICKS(`STS_XFER_MIN_S)),
                      15'(`STS_S_TICKS(`STS_XFER_MAX_S)))
          : 15'(`STS_S_TICKS(`STS_XFER_FIX_S));
      end
      // (R13) Retransfer delay preset.
      STS_RETX_DLY: begin
        preset = pin[`STS_PIN_ADJ]
          ? sts_clamp(cfg_retx, 15'(`STS_S_TICKS(`STS_RETX_MIN_S)),
                      15'(`STS_MIN_TICKS(`STS_RETX_MAX_MIN)))
          : 15'(`STS_MIN_TICKS(`STS_RETX_FIX_MIN));
      end
      // (R15) Stop delay preset.
      STS_STOP_DLY: begin
        preset = pin[`STS_PIN_ADJ]
          ? sts_clamp(cfg_stop, 15'(`STS_S_TICKS(`STS_STOP_MIN_S)),
                      15'(`STS_MIN_TICKS(`STS_STOP_MAX_MIN)))
          : 15'(`STS_MIN_TICKS(`STS_STOP_FIX_MIN));
      end
      // Untimed states load zero, which never expires.
      default: begin
        preset = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state and drives.
  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s = s;
    next_s.sync1 = {stop_delay_cfg_i, retx_delay_cfg_i, xfer_delay_cfg_i,
                    start_delay_cfg_i, adjustable_pkg_i, load_select_switch_i,
                    auto_manual_selector_i, test_request_terminal_n_i,
                    remote_test_input_n_i, emerg_avail_i, normal_avail_i};
    next_s.sync2 = s.sync1;
    case (s.state)
      // (R19) No-load test never leaves normal.
      STS_NORMAL: begin
        if (load_test) begin
          next_s.state = STS_WAIT_EMERG;
        end else if (!normal_eff) begin
          next_s.state = STS_DROPOUT;
        end
      end
      // (R3) Recovery cancels dropout.
      STS_DROPOUT: begin
        if (normal_eff) begin
          next_s.state = STS_NORMAL;
        end else if (timed_out) begin
          next_s.state = STS_START_DLY;
        end
      end
      // (R5) Recovery resets start delay.
      STS_START_DLY: begin
        if (normal_eff) begin
          next_s.state = STS_NORMAL;
        end else if (timed_out) begin
          next_s.state = STS_WAIT_EMERG;
        end
      end
      // (R9) Emergency good starts transfer timing.
      STS_WAIT_EMERG: begin
        if (normal_eff) begin
          next_s.state = STS_STOP_DLY;
        end else if (emerg_ok) begin
          next_s.state = STS_XFER_DLY;
        end
      end
      // (R10) Transfer delay expiry transfers.
      STS_XFER_DLY: begin
        if (normal_eff) begin
          next_s.state = STS_STOP_DLY;
        end else if (!emerg_ok) begin
          next_s.state = STS_WAIT_EMERG;
        end else if (timed_out) begin
          next_s.state = STS_ON_EMERG;
        end
      end
      // (R12) Retransfer only in automatic.
      STS_ON_EMERG: begin
        if (normal_eff && pin[`STS_PIN_AUTO]) begin
          next_s.state = STS_RETX_DLY;
        end
      end
      // (R22) Load test end retransfers first.
      STS_RETX_DLY: begin
        if (!normal_eff || !pin[`STS_PIN_AUTO]) begin
          next_s.state = STS_ON_EMERG;
        end else if (timed_out) begin
          next_s.state = STS_STOP_DLY;
        end
      end
      // (R16) Stop delay expiry ends running.
      STS_STOP_DLY: begin
        if (!normal_eff) begin
          next_s.state = STS_WAIT_EMERG;
        end else if (timed_out) begin
          next_s.state = STS_NORMAL;
        end
      end
      // All eight codes are used; any other value falls back to the normal state.
      default: begin
        next_s.state = STS_NORMAL;
      end
    endcase
    // The timer reloads in the first cycle of every new state.
    next_s.restart = (next_s.state != s.state);

    // (R6) Run from start-delay expiry onward.
    run_req = (next_s.state inside {STS_WAIT_EMERG, STS_XFER_DLY, STS_ON_EMERG,
                                    STS_RETX_DLY, STS_STOP_DLY});
    // (R18) A test runs the set; (R21) its end stops at once.
    run_req = run_req || test_on;
    next_s.gen_start = !run_req;
    next_s.start_3wire = run_req;

    // (R10) Transfer relay while on emergency.
    next_s.xfer_relay = (next_s.state inside {STS_ON_EMERG, STS_RETX_DLY});
    // (R14) Retransfer expiry energizes.
    // (R1) Retransfer relay while on normal; (R23) never with transfer.
    next_s.retx_relay = (next_s.state inside {STS_NORMAL, STS_DROPOUT,
                                              STS_STOP_DLY}) && !next_s.xfer_relay;

    // (R2) Normal lamp held through dropout; (R4) dark in start delay.
    next_s.lamps[0] = (normal_eff || next_s.state == STS_DROPOUT)
                      && next_s.state != STS_START_DLY;
    // (R8) Emergency lamp while generator voltage is good, except in the start delay.
    next_s.lamps[1] = emerg_ok && next_s.state != STS_START_DLY;
    // (R9) Transfer timing lamp.
    next_s.lamps[2] = (next_s.state == STS_XFER_DLY);
    // (R13) Retransfer timing lamp.
    next_s.lamps[3] = (next_s.state == STS_RETX_DLY);
    // (R11) Transfer active lamp.
    next_s.lamps[4] = next_s.xfer_relay;
    // (R1) Retransfer active lamp.
    next_s.lamps[5] = next_s.retx_relay && next_s.state != STS_START_DLY;
    // (R7) Start lamp follows the run request.
    next_s.lamps[6] = run_req;
    // (R15) Stop timing lamp.
    next_s.lamps[7] = (next_s.state == STS_STOP_DLY);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  ////////////////////////////////////////////////////////////////////////////

  // Registers the whole record; reset energizes only the start relay.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      // Synchronisers start at idle pin levels, so no false test or outage follows reset.
      s.sync1[`STS_PIN_W-1:0] <= `STS_RST_PINS;
      s.sync2[`STS_PIN_W-1:0] <= `STS_RST_PINS;
      s.state <= STS_NORMAL;
      s.restart <= 1'b1;
      s.gen_start <= `STS_RST_GEN_START;
      s.xfer_relay <= `STS_RST_XFER_RELAY;
      s.retx_relay <= `STS_RST_RETX_RELAY;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.
  ////////////////////////////////////////////////////////////////////////////

  assign gen_start_relay_o = s.gen_start;
  assign transfer_control_relay_o = s.xfer_relay;
  assign retransfer_control_relay_o = s.retx_relay;
  assign start_3wire_o = s.start_3wire;
  assign lamp_normal_avail_o = s.lamps[0];
  assign lamp_emerg_avail_o = s.lamps[1];
  assign lamp_xfer_timing_o = s.lamps[2];
  assign lamp_retx_timing_o = s.lamps[3];
  assign lamp_xfer_active_o = s.lamps[4];
  assign lamp_retx_active_o = s.lamps[5];
  assign lamp_start_o = s.lamps[6];
  assign lamp_stop_timing_o = s.lamps[7];
endmodule

//--- test/sts_sequencer_chk.sv
`timescale 1ns/1ps
// Watches relay and lamp relations at the sequencer pins.
module sts_sequencer_chk (
  // Clock, reset and inputs.
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic normal_avail_i,
  input wire logic remote_test_input_n_i,
  input wire logic test_request_terminal_n_i,
  input wire logic load_select_switch_i,
  // Relay drives and lamps.
  input wire logic gen_start_relay_o,
  input wire logic transfer_control_relay_o,
  input wire logic retransfer_control_relay_o,
  input wire logic start_3wire_o,
  input wire logic lamp_normal_avail_o,
  input wire logic lamp_xfer_timing_o,
  input wire logic lamp_retx_timing_o,
  input wire logic lamp_retx_active_o,
  input wire logic lamp_start_o,
  input wire logic lamp_stop_timing_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  a_relays_apart: assert property (
    !(transfer_control_relay_o && retransfer_control_relay_o))
    else $error("transfer and retransfer relays on together");
  a_lamp_run: assert property (lamp_start_o == !gen_start_relay_o)
    else $error("start lamp differs from run request");
  a_wire3_run: assert property (start_3wire_o == !gen_start_relay_o)
    else $error("three-wire start differs from start relay");
  a_xfer_run: assert property (transfer_control_relay_o |-> !gen_start_relay_o)
    else $error("transfer relay on without run request");
  a_timing_one: assert property (
    $onehot0({lamp_xfer_timing_o, lamp_retx_timing_o, lamp_stop_timing_o}))
    else $error("two timing lamps lit");
  a_xfer_after_timing: assert property (
    $rose(transfer_control_relay_o) |-> $past(lamp_xfer_timing_o))
    else $error("transfer relay on without transfer timing");
  a_stop_on_normal: assert property (
    $rose(lamp_stop_timing_o) |-> retransfer_control_relay_o)
    else $error("stop timing without retransfer relay");
  a_dropout_lamps: assert property ($fell(normal_avail_i) && gen_start_relay_o &&
    retransfer_control_relay_o && remote_test_input_n_i && test_request_terminal_n_i
    |-> ##1 (lamp_normal_avail_o && lamp_retx_active_o)[*8])
    else $error("normal lamps dropped during dropout");
  a_test_run: assert property ($fell(remote_test_input_n_i) && test_request_terminal_n_i
    |-> ##[1:5] !gen_start_relay_o)
    else $error("test request did not start generator");
  a_noload_end: assert property (
    $rose(remote_test_input_n_i) && test_request_terminal_n_i && !load_select_switch_i &&
    normal_avail_i && retransfer_control_relay_o && !lamp_stop_timing_o
    |-> ##[1:5] gen_start_relay_o)
    else $error("no-load test end did not stop generator");
endmodule

//--- test/sts_genset_model.sv
`timescale 1ns/1ps
// Generator set and the two contactors as seen from the relay drives.
module sts_genset_model (
  // Clock and relay drives.
  input wire logic ref_clk_i,
  input wire logic gen_start_relay_i,
  input wire logic start_3wire_i,
  input wire logic transfer_control_relay_i,
  input wire logic retransfer_control_relay_i,
  input wire logic [7:0] pickup_cycles_i,
  // Generator voltage good and contactor states.
  output logic emerg_avail_o,
  output logic normal_contactor_o,
  output logic emergency_contactor_o
);
  int run_cnt = 0;
  initial begin
    emerg_avail_o = 1'b0;
    normal_contactor_o = 1'b0;
    emergency_contactor_o = 1'b0;
  end
  // Voltage builds some cycles after a run request and collapses after it ends.
  always @(posedge ref_clk_i) begin
    if (!gen_start_relay_i || start_3wire_i) begin
      run_cnt <= (run_cnt < 1000) ? run_cnt + 1 : run_cnt;
    end else begin
      run_cnt <= (run_cnt > pickup_cycles_i + 8) ? pickup_cycles_i + 8
                                                 : (run_cnt > 0 ? run_cnt - 1 : 0);
    end
    emerg_avail_o <= (run_cnt > pickup_cycles_i);
    // the emergency coil closes only once the normal contactor has opened.
    normal_contactor_o <= retransfer_control_relay_i && !transfer_control_relay_i;
    emergency_contactor_o <= transfer_control_relay_i && !normal_contactor_o;
  end
endmodule

//--- test/sts_sequencer_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the transfer sequencer.
module sts_sequencer_tb;
  logic ref_clk_i, resetn_i, normal, test_n, term_n, auto, load, adj;
  logic [14:0] start_cfg;
  logic [7:0] pk;
  wire logic emerg, nc, ec;
  // Outputs: gen,xfer,retx,3wire, lamps normal,emerg,xt,rt,xa,ra,start,stop.
  wire logic [11:0] ov;
  int err_count, compares, n, sc;
  // Expected outputs and care masks for each model phase.
  logic [11:0] exp_v [8] = '{12'hA84, 12'h800, 12'h102, 12'h162, 12'h54A, 12'h5D2, 12'h3C3,
                             12'h5CA};
  logic [11:0] msk_v [8] = '{12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF, 12'hFF7, 12'hFFB,
                             12'hFFF};
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end

  sts_sequencer #(.TICK_CYCLES(10)) dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .normal_avail_i(normal), .emerg_avail_i(emerg), .remote_test_input_n_i(test_n),
    .test_request_terminal_n_i(term_n), .auto_manual_selector_i(auto),
    .load_select_switch_i(load), .adjustable_pkg_i(adj), .start_delay_cfg_i(start_cfg),
    .xfer_delay_cfg_i(15'h0014), .retx_delay_cfg_i(15'h003C), .stop_delay_cfg_i(15'h0014),
    .gen_start_relay_o(ov[11]), .transfer_control_relay_o(ov[10]),
    .retransfer_control_relay_o(ov[9]), .start_3wire_o(ov[8]), .lamp_normal_avail_o(ov[7]),
    .lamp_emerg_avail_o(ov[6]), .lamp_xfer_timing_o(ov[5]), .lamp_retx_timing_o(ov[4]),
    .lamp_xfer_active_o(ov[3]), .lamp_retx_active_o(ov[2]), .lamp_start_o(ov[1]),
    .lamp_stop_timing_o(ov[0]));
  sts_genset_model u_gen (.ref_clk_i(ref_clk_i), .gen_start_relay_i(ov[11]),
    .start_3wire_i(ov[8]), .transfer_control_relay_i(ov[10]),
    .retransfer_control_relay_i(ov[9]), .pickup_cycles_i(pk), .emerg_avail_o(emerg),
    .normal_contactor_o(nc), .emergency_contactor_o(ec));

  // Clock at 200 MHz.
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Compares all cared-for outputs with one phase of the model.
  task cmp(input int p);
    `CHK("outputs", exp_v[p] & msk_v[p], ov & msk_v[p])
  endtask
  // Waits, bounded, for one output bit; n counts the cycles.
  task wt(input int b, input logic v, input int lim);
    n = 0;
    while (ov[b] !== v && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (ov[b] !== v) begin
      err_count++;
      $display("[ERR] wait bit %0d exp %b got %b", b, v, ov[b]);
    end
  endtask
  // Checks the last wait against a delay of t ticks of 10 cycles.
  task dly(input int t);
    `CHK("delay ok", 1'b1, (n >= (t - 1) * 10 - 4 && n <= t * 10 + 8))
  endtask
  task test_done;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    test_done;
  end
  // Main sequence.
  initial begin
    err_count = 0;
    compares = 0;
    sc = $urandom(25938);
    sc = 5 + $urandom % 4;
    start_cfg = sc[14:0];
    pk = 8'(30 + $urandom % 30);
    {resetn_i, normal, test_n, term_n, auto, load, adj} = 7'h3D;
    repeat (12) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    cmp(0);
    // A dip shorter than dropout leaves the panel alone.
    normal = 1'b0;
    repeat (40) @(negedge ref_clk_i);
    normal = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    cmp(0);
    // Outage that ends during the start delay.
    normal = 1'b0;
    wt(7, 1'b0, 200);
    dly(8);
    cmp(1);
    repeat (20) @(negedge ref_clk_i);
    normal = 1'b1;
    wt(7, 1'b1, 20);
    repeat (sc * 10 + 20) @(negedge ref_clk_i);
    cmp(0);
    // Full outage, transfer, manual hold, retransfer and stop.
    normal = 1'b0;
    wt(7, 1'b0, 200);
    wt(11, 1'b0, 200);
    dly(sc);
    repeat (2) @(negedge ref_clk_i);
    cmp(2);
    wt(6, 1'b1, 100);
    repeat (2) @(negedge ref_clk_i);
    cmp(3);
    wt(10, 1'b1, 400);
    dly(20);
    repeat (3) @(negedge ref_clk_i);
    cmp(4);
    `CHK("contactors", 2'b01, {nc, ec})
    auto = 1'b0;
    normal = 1'b1;
    repeat (800) @(negedge ref_clk_i);
    cmp(7);
    auto = 1'b1;
    wt(4, 1'b1, 10);
    cmp(5);
    wt(9, 1'b1, 700);
    dly(60);
    repeat (3) @(negedge ref_clk_i);
    cmp(6);
    `CHK("contactors", 2'b10, {nc, ec})
    wt(11, 1'b1, 300);
    dly(20);
    repeat (2) @(negedge ref_clk_i);
    wt(6, 1'b0, 100);
    cmp(0);
    repeat (80) @(negedge ref_clk_i);
    // No-load test, held low for the whole test period.
    // request held until the test ends
    test_n = 1'b0;
    wt(11, 1'b0, 6);
    repeat (300) @(negedge ref_clk_i);
    `CHK("xfer relay", 1'b0, ov[10])
    test_n = 1'b1;
    wt(11, 1'b1, 6);
    repeat (80) @(negedge ref_clk_i);
    // On-load exercise from the exerciser terminal.
    load = 1'b1;
    term_n = 1'b0;
    wt(11, 1'b0, 6);
    wt(10, 1'b1, 400);
    term_n = 1'b1;
    wt(4, 1'b1, 10);
    wt(9, 1'b1, 700);
    wt(11, 1'b1, 300);
    dly(20);
    repeat (20) @(negedge ref_clk_i);
    // Fixed package: the start delay ignores the adjustable preset.
    adj = 1'b0;
    normal = 1'b0;
    wt(7, 1'b0, 200);
    wt(11, 1'b0, 400);
    dly(30);
    test_done;
  end
endmodule

bind sts_sequencer sts_sequencer_chk u_chk (.*);
